//--- inc/pcfetch_pkg.sv
// Purpose: shared constants and carriers for the program counter fetch unit
// Assumes: 21-bit byte address space, 16-bit instruction words
// Notes: opcode prefixes are this core's own encoding choice
package pcfetch_pkg;
	localparam int PC_WIDTH = 21;
	localparam int WORD_WIDTH = 16;
	localparam logic [20:0] PC_RESET = 21'h000000;
	localparam logic [20:0] WORD_STEP = 21'h000002;
	// upper nibble of a continuation (second) word
	localparam logic [3:0] SECOND_MARK = 4'hf;
	// first-word opcode prefixes of the two-word instructions
	localparam logic [3:0] OP_MOVE_FF = 4'hc;
	localparam logic [6:0] OP_CALL = 7'h76;
	localparam logic [7:0] OP_JUMP = 8'hef;
	localparam logic [9:0] OP_LOAD_PTR = 10'h3b8;
	// relative branch: 11-bit and 8-bit offsets
	localparam logic [4:0] OP_BRA_LONG = 5'h1a;
	localparam logic [4:0] OP_BRA_COND = 5'h1c;

	// one decoded control request from the execute stage
	typedef struct packed {
		logic fetch_en;
		logic take_branch;
		logic skip;
	} ctrl_s;

	// word delivered downstream
	typedef struct packed {
		logic valid;
		logic is_nop;
		logic [15:0] first;
		logic [11:0] literal;
	} issue_s;
endpackage : pcfetch_pkg

//--- core/program_counter_word_fetch.sv
// Purpose: program counter and instruction word addressing for an 8-bit core
// Assumes: program memory answers a byte address with a word in one cycle
// Notes: one fetch per enabled cycle; second words are fetched in sequence

// Summary of operation
// RQ1: memory addressed by byte; instructions are one or two 16-bit words
// RQ2: instruction word low byte sits at even address, bit 0 zero
// RQ3: counter steps by two per word; bit 0 always reads zero
// RQ4: absolute jump and call load their word address into counter bits 20:1
// RQ5: relative branch offset counts words, so counter moves twice the offset
// RQ6: second word has upper nibble ones, lower twelve bits literal data
// RQ7: second word reached alone executes as a no-operation
// RQ8: first word of a pair fetches the next word, counter passes both
module program_counter_word_fetch
	import pcfetch_pkg::*;
#(
	parameter int ADDR_WIDTH = PC_WIDTH
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// control from execute stage
	input wire ctrl_s ctrl,
	// program memory
	input wire logic [15:0] mem_rdata,
	output logic [20:0] mem_addr,
	// issue to decoder
	output issue_s issue,
	output logic [20:0] pc
);

	// refuse a width that the fixed 21-bit address ports cannot carry
	if (ADDR_WIDTH != PC_WIDTH)
	begin : g_bad_width
		$error("address width must be 21");
	end

	typedef enum logic [1:0] {ST_FIRST, ST_SECOND} fetch_e;

	fetch_e state_reg, state_next;
	logic [20:1] pcw_reg, pcw_next;
	logic [15:0] first_reg, first_next;
	logic pair_reg, pair_next;
	issue_s issue_reg, issue_next;
	logic is_pair;
	logic is_mark;
	logic [20:1] rel_off;
	logic [20:1] abs_tgt;

	////////////////////////////////////////////////////////////////////////
	// decode of the word arriving from memory
	always_comb
	begin
		is_mark = mem_rdata[15:12] == SECOND_MARK; // RQ6
		is_pair = mem_rdata[15:12] == OP_MOVE_FF
			|| mem_rdata[15:9] == OP_CALL
			|| mem_rdata[15:8] == OP_JUMP
			|| mem_rdata[15:6] == OP_LOAD_PTR; // RQ1
		// word offset sign-extended; word units keep bit 0 clear
		if (mem_rdata[15:11] == OP_BRA_LONG)
			rel_off = {{9{mem_rdata[10]}}, mem_rdata[10:0]}; // RQ5
		else
			rel_off = {{12{mem_rdata[7]}}, mem_rdata[7:0]}; // RQ5
		abs_tgt = {mem_rdata[11:0], first_reg[7:0]}; // RQ4
	end

	////////////////////////////////////////////////////////////////////////
	// fetch sequencing; counter kept as a word address so bit 0 cannot set
	always_comb
	begin
		state_next = state_reg;
		pcw_next = pcw_reg;
		first_next = first_reg;
		pair_next = pair_reg;
		issue_next = '0;
		if (ctrl.fetch_en)
		begin
			pcw_next = pcw_reg + 20'h00001; // RQ3
			unique case (state_reg)
				ST_FIRST:
				begin
					if (ctrl.skip)
						pair_next = 1'b0;
					else if (is_pair)
					begin
						// hold the first word until its partner arrives
						first_next = mem_rdata; // RQ8
						pair_next = 1'b1;
						state_next = ST_SECOND; // RQ8
					end
					else if (is_mark)
					begin
						// orphan continuation word
						issue_next.valid = 1'b1;
						issue_next.is_nop = 1'b1; // RQ7
						issue_next.first = mem_rdata;
					end
					else
					begin
						issue_next.valid = 1'b1;
						issue_next.first = mem_rdata;
						if (ctrl.take_branch
							&& (mem_rdata[15:11] == OP_BRA_LONG
							|| mem_rdata[15:11] == OP_BRA_COND))
							pcw_next = pcw_reg + 20'h00001 + rel_off; // RQ5
					end
				end
				ST_SECOND:
				begin
					state_next = ST_FIRST;
					pair_next = 1'b0;
					issue_next.valid = 1'b1;
					issue_next.first = first_reg;
					issue_next.literal = mem_rdata[11:0]; // RQ6
					if (first_reg[15:8] == OP_JUMP
						|| first_reg[15:9] == OP_CALL)
						pcw_next = abs_tgt; // RQ4
				end
				default:
					state_next = ST_FIRST;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state registers
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= ST_FIRST;
			pcw_reg <= PC_RESET[20:1];
			first_reg <= 16'h0000;
			pair_reg <= 1'b0;
			issue_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			pcw_reg <= pcw_next;
			first_reg <= first_next;
			pair_reg <= pair_next;
			issue_reg <= issue_next;
		end
	end

	// byte address outputs, low bit tied to even
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			mem_addr <= PC_RESET;
			pc <= PC_RESET;
		end
		else
		begin
			mem_addr <= {pcw_next, 1'b0}; // RQ2
			pc <= {pcw_next, 1'b0}; // RQ3
		end
	end

	assign issue = issue_reg;

	////////////////////////////////////////////////////////////////////////
	// checks; all sample on the one system clock and rest during reset
	default clocking cb_chk @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	sequence s_pair_start;
		ctrl.fetch_en && state_reg == ST_FIRST && !ctrl.skip && is_pair;
	endsequence

	// a word counter can never show an odd byte address
	a_pc_even: assert property ( // RQ2
		pc[0] == 1'b0 && mem_addr[0] == 1'b0)
		else $error("counter not word aligned");
	a_pc_step: assert property ( // RQ3
		ctrl.fetch_en && state_reg == ST_FIRST && !is_pair && !is_mark
			&& !ctrl.take_branch |=> pc == $past(pc) + WORD_STEP)
		else $error("counter did not step by two");
	// without a fetch nothing may move or issue
	a_idle_hold: assert property ( // RQ3
		!ctrl.fetch_en |=> pc == $past(pc) && !issue.valid)
		else $error("counter moved without a fetch");
	a_pair_second: assert property ( // RQ8
		s_pair_start |=> state_reg == ST_SECOND && pair_reg)
		else $error("second word not fetched");
	a_orphan_nop: assert property ( // RQ7
		ctrl.fetch_en && state_reg == ST_FIRST && !ctrl.skip && is_mark
			|=> issue.valid && issue.is_nop)
		else $error("orphan second word not a nop");
	// a word skipped in the first-word state issues nothing but still advances one word
	a_skip_drop: assert property ( // RQ7
		ctrl.fetch_en && state_reg == ST_FIRST && ctrl.skip
			|=> !issue.valid && pc == $past(pc) + WORD_STEP)
		else $error("skipped word was issued");
	a_jump_load: assert property ( // RQ4
		ctrl.fetch_en && state_reg == ST_SECOND
			&& first_reg[15:8] == OP_JUMP
			|=> pc[20:1] == $past(abs_tgt))
		else $error("jump target not loaded");
	a_call_load: assert property ( // RQ4
		ctrl.fetch_en && state_reg == ST_SECOND
			&& first_reg[15:9] == OP_CALL
			|=> pc[20:1] == $past(abs_tgt))
		else $error("call target not loaded");
	a_rel_branch: assert property ( // RQ5
		ctrl.fetch_en && state_reg == ST_FIRST && !ctrl.skip
			&& ctrl.take_branch && mem_rdata[15:11] == OP_BRA_LONG
			|=> pc == $past(pc) + WORD_STEP + {$past(rel_off), 1'b0})
		else $error("branch offset not word scaled");
	a_cond_branch: assert property ( // RQ5
		ctrl.fetch_en && state_reg == ST_FIRST && !ctrl.skip
			&& ctrl.take_branch && mem_rdata[15:11] == OP_BRA_COND
			|=> pc == $past(pc) + WORD_STEP + {$past(rel_off), 1'b0})
		else $error("short branch offset not word scaled");
	a_literal_pass: assert property ( // RQ6
		ctrl.fetch_en && state_reg == ST_SECOND
			|=> issue.valid && issue.literal == $past(mem_rdata[11:0]))
		else $error("second word literal lost");
	a_pair_return: assert property ( // RQ1
		s_pair_start ##1 ctrl.fetch_en |=> state_reg == ST_FIRST)
		else $error("pair did not complete in two words");
endmodule : program_counter_word_fetch

//--- sim/prog_mem_model.sv
// Purpose: byte-wide program memory model facing the fetch unit
// Assumes: 64 bytes hold every scenario's code
// Notes: combinational read; unwritten bytes read as ff
module prog_mem_model
(
	// fetch side
	input wire logic [20:0] mem_addr,
	output logic [15:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem_bytes [0:63];
	// erased cells read high, never a stale word
	initial
	begin
		foreach (mem_bytes[i]) mem_bytes[i] = 8'hff;
	end
	// low byte at the even address, high byte at the odd one above
	always_comb
	begin
		mem_rdata = {mem_bytes[mem_addr[5:0] | 6'h01],
			mem_bytes[mem_addr[5:0]]};
	end
endmodule : prog_mem_model

//--- sim/program_counter_word_fetch_tb_top.sv
// Purpose: self-checking bench for the program counter fetch unit
// Assumes: one fetch per cycle, answer one edge later
// Notes: inputs change on the falling edge only
module program_counter_word_fetch_tb_top;
	import pcfetch_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	ctrl_s ctrl = '0;
	logic [15:0] mem_rdata;
	logic [20:0] mem_addr;
	logic [20:0] pc;
	issue_s issue;
	int n_fail = 0;
	int checked = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////////////////
	program_counter_word_fetch u_program_counter_word_fetch (.clk_sys,
		.nrst, .ctrl, .mem_rdata, .mem_addr, .issue, .pc);
	prog_mem_model u_prog_mem_model (.mem_addr, .mem_rdata);
	// 50 ns clock; the cycle ceiling cuts a hang short
	initial
	begin
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_fail++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task check(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	task put(input int a, input logic [15:0] w);
		u_prog_mem_model.mem_bytes[a] = w[7:0];
		u_prog_mem_model.mem_bytes[a + 1] = w[15:8];
	endtask : put
	// one control cycle; results looked at just after the answering edge
	task drive(input ctrl_s c);
		@(negedge clk_sys);
		ctrl = c;
		@(posedge clk_sys);
		#1;
	endtask : drive
	task step(input logic br);
		drive({1'b1, br, 1'b0});
	endtask : step
	task t_plain;
		step(1'b0);
		check("valid", issue.valid, 1);
		check("pc", pc, 21'h000002);
		check("addr", mem_addr, 21'h000002);
		check("literal", issue.literal, 0);
	endtask : t_plain
	// jump pair: nothing issued on the first word
	task t_jump;
		step(1'b0);
		check("valid", issue.valid, 0);
		check("pc", pc, 21'h000004);
		step(1'b0);
		check("first", issue.first, 16'hef03);
		check("pc", pc, 21'h000006);
	endtask : t_jump
	task t_pair;
		step(1'b0);
		step(1'b0);
		check("literal", issue.literal, 12'h456);
		check("nop", issue.is_nop, 0);
		check("pc", pc, 21'h00000a);
	endtask : t_pair
	task t_orphan;
		step(1'b0);
		check("nop", issue.is_nop, 1);
		check("pc", pc, 21'h00000c);
	endtask : t_orphan
	// offset 3 words moves 6 bytes past the next word
	task t_branch;
		step(1'b1);
		check("pc", pc, 21'h000014);
	endtask : t_branch
	// skipped first word: its partner then runs alone as a nop
	task t_skip;
		drive({1'b1, 1'b0, 1'b1});
		check("valid", issue.valid, 0);
		check("pc", pc, 21'h000016);
		step(1'b0);
		check("valid", issue.valid, 1);
		check("nop", issue.is_nop, 1);
		check("pc", pc, 21'h000018);
	endtask : t_skip
	// call pair lands on word 0e, byte 1c
	task t_call;
		step(1'b0);
		check("valid", issue.valid, 0);
		step(1'b0);
		check("first", issue.first, 16'hec0e);
		check("pc", pc, 21'h00001c);
	endtask : t_call
	// no fetch holds all; a branch flag on a plain word is ignored
	task t_refuse;
		drive({1'b0, 1'b1, 1'b0});
		check("valid", issue.valid, 0);
		check("pc", pc, 21'h00001c);
		step(1'b1);
		check("first", issue.first, 16'h0e01);
		check("pc", pc, 21'h00001e);
	endtask : t_refuse
	task t_load;
		step(1'b0);
		step(1'b0);
		check("first", issue.first, 16'hee00);
		check("literal", issue.literal, 12'h0ab);
		check("pc", pc, 21'h000022);
	endtask : t_load
	// short branch of -16 words from word 11 lands on byte 4
	task t_back;
		step(1'b1);
		check("pc", pc, 21'h000004);
	endtask : t_back
	// mid-run reset clears counter and issue at once, then fetch restarts
	task t_reset;
		@(negedge clk_sys);
		ctrl = '0;
		nrst = 1'b0;
		#1;
		check("pc", pc, 21'h000000);
		check("valid", issue.valid, 0);
		repeat (2) @(negedge clk_sys);
		nrst = 1'b1;
		step(1'b0);
		check("first", issue.first, 16'h0e55);
		check("pc", pc, 21'h000002);
	endtask : t_reset
	////////////////////////////////////////////////////////////////////////
	task test_done;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (8) @(negedge clk_sys);
		put(0, 16'h0e55);
		put(2, 16'hef03);
		put(4, 16'hf000);
		put(6, 16'hc123);
		put(8, 16'hf456);
		put(10, 16'hf789);
		put(12, 16'hd003);
		put(20, 16'hc123);
		put(22, 16'hf456);
		put(24, 16'hec0e);
		put(26, 16'hf000);
		put(28, 16'h0e01);
		put(30, 16'hee00);
		put(32, 16'hf0ab);
		put(34, 16'he0f0);
		check("pc", pc, 21'h000000);
		nrst = 1'b1;
		t_plain();
		t_jump();
		t_pair();
		t_orphan();
		t_branch();
		t_skip();
		t_call();
		t_refuse();
		t_load();
		t_back();
		t_reset();
		@(negedge clk_sys);
		ctrl = '0;
		test_done();
	end
endmodule : program_counter_word_fetch_tb_top
